// File: core/isc_pkg.sv
package isc_pkg;

  // Peripheral source counts
  localparam int NUM_DMA = 4;
  localparam int NUM_TA = 5;
  localparam int NUM_TB = 6;
  localparam int NUM_UART = 5;
  localparam int NUM_BUSCOL = 3;
  localparam int NUM_KEY = 4;
  localparam int NUM_EXT = 6;
  localparam int NUM_PERIPH = 36;
  localparam int ADDR_W = 24;
  localparam int SWNUM_W = 6;
  localparam int LVL_W = 3;

  // Peripheral source index, vector number is base plus index
  localparam int SRC_DMA0 = 0;
  localparam int SRC_TA0 = 4;
  localparam int SRC_TB0 = 9;
  localparam int SRC_AD = 15;
  localparam int SRC_UTX0 = 16;
  localparam int SRC_URX0 = 21;
  localparam int SRC_BUS0 = 26;
  localparam int SRC_KEY = 29;
  localparam int SRC_EXT0 = 30;
  localparam int PERIPH_VEC_BASE = 8;
  localparam int SW_STACK_LIMIT = 32;
  localparam int BRK_VECTOR = 0;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MATCH = 8'h04;
  localparam logic [7:0] REG_EXTMODE = 8'h08;
  localparam logic [7:0] REG_PEND_LO = 8'h0c;
  localparam logic [7:0] REG_PEND_HI = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_LEVEL_BASE = 8'h20;
  localparam int LEVELS_PER_WORD = 8;
  localparam int LEVEL_FIELD_W = 4;
  localparam int PEND_LO_W = 32;

  // Control register fields
  localparam int CTRL_IEN = 0;
  localparam int CTRL_STEP = 1;
  localparam int CTRL_AMEN = 2;
  localparam int CTRL_IPL_LSB = 4;
  localparam int CTRL_SER_LSB = 8;
  localparam int SER_MODE_W = 2;
  localparam int EXT_MODE_W = 3;

  // Status register fields
  localparam int STAT_OVF = 0;
  localparam int STAT_USEL = 1;
  localparam int STAT_USAVED = 2;
  localparam int STAT_SPEC_LSB = 8;
  localparam int NUM_SPEC = 9;

  typedef enum logic [1:0] {
    SER_NORMAL = 2'h0,
    SER_I2C = 2'h1,
    SER_SS = 2'h2
  } ser_mode_e;

  typedef enum logic [2:0] {
    EXT_FALL = 3'h0,
    EXT_RISE = 3'h1,
    EXT_BOTH = 3'h2,
    EXT_LOW = 3'h3,
    EXT_HIGH = 3'h4
  } ext_mode_e;

  typedef enum logic [3:0] {
    GK_NONE = 4'h0,
    GK_NMI = 4'h1,
    GK_WDT = 4'h3,
    GK_AMATCH = 4'h2,
    GK_STEP = 4'h6,
    GK_UND = 4'h7,
    GK_OVF = 4'h5,
    GK_BRK = 4'h4,
    GK_DEBUG_BREAK_OP = 4'hc,
    GK_SWINT = 4'hd,
    GK_PERIPH = 4'hf
  } grant_kind_e;

endpackage : isc_pkg

// File: core/interrupt_source_classifier.sv
`timescale 1ns/1ps
// Functional notes
// - Peripheral requests need global enable and level above IPL; special ones bypass both.
// - Every trap instruction request is granted regardless of global enable.
// - Illegal-op execution always raises the undefined-instruction trap.
// - Overflow trap instruction raises interrupt only when excess flag is 1.
// - Arithmetic-class instructions update the excess flag.
// - Break raises break trap; debug break raises separate debugger trap.
// - Software trap takes number 0 to 63 and raises that number.
// - Software numbers 8 to 43 share vectors with peripheral requests.
// - Software numbers 0 to 31 save and clear stack select, restore on return.
// - Software numbers 32 to 63 leave stack select untouched.
// - Peripheral requests always save and clear stack select.
// - Reset, NMI, watchdog, address match, step are special; low pins act.
// - Enabled address match fires before instruction at compare address.
// - Compare address not at an instruction start never matches.
// - Step flag set raises single-step after each completed instruction.
// - Peripheral requests are maskable and use vectors 8 to 43.
// - Shared serial request: collision, start/stop in I2C, fault with slave select on channels 1 and 2 (collision on channel 0).
// - Low on any key input pin raises key-input request.
// - External pins sense rising, falling, both edges, or high, low level.
// - Requests for DMA, timers A and B, A-D, serial transmit and receive.
module interrupt_source_classifier
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic rstPin_b,
  input wire logic nmiPin_b,
  input wire logic [isc_pkg::NUM_KEY-1:0] keyInputPin_b,
  input wire logic [isc_pkg::NUM_EXT-1:0] externalRequestPin,
  // Peripheral requests
  input wire logic [isc_pkg::NUM_DMA-1:0] dmaReq,
  input wire logic [isc_pkg::NUM_TA-1:0] timerAReq,
  input wire logic [isc_pkg::NUM_TB-1:0] timerBReq,
  input wire logic adReq,
  input wire logic [isc_pkg::NUM_UART-1:0] uartTxReq,
  input wire logic [isc_pkg::NUM_UART-1:0] uartRxReq,
  input wire logic [isc_pkg::NUM_BUSCOL-1:0] busCollision,
  input wire logic [isc_pkg::NUM_BUSCOL-1:0] startStopDet,
  input wire logic [isc_pkg::NUM_BUSCOL-1:0] faultErr,
  input wire logic watchdogReq,
  // CPU core events
  input wire logic cpuReady,
  input wire logic instrStart,
  input wire logic instrDone,
  input wire logic [isc_pkg::ADDR_W-1:0] instrAddr,
  input wire logic illegalOpExec,
  input wire logic overflowTrapExec,
  input wire logic breakOpExec,
  input wire logic debugBreakOpExec,
  input wire logic swTrapExec,
  input wire logic [isc_pkg::SWNUM_W-1:0] swTrapNum,
  input wire logic ovfUpdate,
  input wire logic ovfValue,
  input wire logic intReturn,
  input wire logic stackSelWrite,
  input wire logic stackSelValue,
  // CPU core grant
  output logic grantValid,
  output isc_pkg::grant_kind_e grantKind,
  output logic [isc_pkg::SWNUM_W-1:0] grantVector,
  output logic grantStackSwitch,
  output logic stackSelFlag,
  output logic ovfFlag,
  output logic resetRequest
);
  import isc_pkg::*;

  typedef struct packed {
    logic rstS1;
    logic rstS2;
    logic nmiS1;
    logic nmiS2;
    logic nmiSeen;
    logic [NUM_KEY-1:0] keyS1;
    logic [NUM_KEY-1:0] keyS2;
    logic keySeen;
    logic [NUM_EXT-1:0] extS1;
    logic [NUM_EXT-1:0] extS2;
    logic [NUM_EXT-1:0] extPrev;
    logic [NUM_PERIPH-1:0] pend;
    logic [NUM_SPEC-1:0] spec;
    logic [SWNUM_W-1:0] swNum;
    logic iEn;
    logic dStep;
    logic amEn;
    logic [LVL_W-1:0] ipl;
    logic [NUM_BUSCOL-1:0][SER_MODE_W-1:0] serMode;
    logic [ADDR_W-1:0] matchAddr;
    logic [NUM_EXT-1:0][EXT_MODE_W-1:0] extMode;
    logic [NUM_PERIPH-1:0][LVL_W-1:0] level;
    logic ovfFlag;
    logic uFlag;
    logic uSaved;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic grantValid;
    grant_kind_e grantKind;
    logic [SWNUM_W-1:0] grantVector;
    logic grantStackSwitch;
    logic resetRequest;
  } state_s;

  // Special pending bit positions, in grant priority order
  localparam int SP_NMI = 0;
  localparam int SP_WDT = 1;
  localparam int SP_AM = 2;
  localparam int SP_STEP = 3;
  localparam int SP_UND = 4;
  localparam int SP_OVF = 5;
  localparam int SP_BRK = 6;
  localparam int SP_DEBUG_BREAK_OP = 7;
  localparam int SP_SW = 8;

  state_s s_reg;
  state_s s_next;
  logic [NUM_PERIPH-1:0] setVec;
  logic [NUM_PERIPH-1:0] clrVec;
  logic [NUM_SPEC-1:0] specSet;
  logic [NUM_SPEC-1:0] specClr;
  logic [31:0] rdWord;
  logic hit;
  logic take;
  logic found;
  logic [LVL_W-1:0] bestLvl;
  logic [SWNUM_W-1:0] bestIdx;

  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.grantValid = 1'b0;
    s_next.grantStackSwitch = 1'b0;
    setVec = '0;
    clrVec = '0;
    specSet = '0;
    specClr = '0;
    rdWord = '0;
    hit = 1'b1;
    take = 1'b0;
    found = 1'b0;
    bestLvl = s_reg.ipl;
    bestIdx = '0;

    s_next.rstS1 = rstPin_b;
    s_next.rstS2 = s_reg.rstS1;
    s_next.nmiS1 = nmiPin_b;
    s_next.nmiS2 = s_reg.nmiS1;
    s_next.keyS1 = keyInputPin_b;
    s_next.keyS2 = s_reg.keyS1;
    s_next.extS1 = externalRequestPin;
    s_next.extS2 = s_reg.extS1;
    s_next.extPrev = s_reg.extS2;
    s_next.resetRequest = ~s_reg.rstS2;
    specSet[SP_NMI] = ~s_reg.nmiS2 & ~s_reg.nmiSeen;
    s_next.nmiSeen = ~s_reg.nmiS2;
    specSet[SP_WDT] = watchdogReq;
    specSet[SP_AM] = s_reg.amEn & instrStart & (instrAddr == s_reg.matchAddr);
    specSet[SP_STEP] = s_reg.dStep & instrDone;
    specSet[SP_UND] = illegalOpExec;
    specSet[SP_OVF] = overflowTrapExec & s_reg.ovfFlag;
    specSet[SP_BRK] = breakOpExec;
    specSet[SP_DEBUG_BREAK_OP] = debugBreakOpExec;
    specSet[SP_SW] = swTrapExec;
    if (swTrapExec) begin
      s_next.swNum = swTrapNum;
    end
    if (ovfUpdate) begin
      s_next.ovfFlag = ovfValue;
    end

    setVec[SRC_DMA0 +: NUM_DMA] = dmaReq;
    setVec[SRC_TA0 +: NUM_TA] = timerAReq;
    setVec[SRC_TB0 +: NUM_TB] = timerBReq;
    setVec[SRC_AD] = adReq;
    setVec[SRC_UTX0 +: NUM_UART] = uartTxReq;
    setVec[SRC_URX0 +: NUM_UART] = uartRxReq;
    for (int c = 0; c < NUM_BUSCOL; c++) begin
      unique case (s_reg.serMode[c])
        SER_I2C: setVec[SRC_BUS0 + c] = startStopDet[c];
        SER_SS: setVec[SRC_BUS0 + c] = (c == 0) ? busCollision[c] : faultErr[c];
        default: setVec[SRC_BUS0 + c] = busCollision[c];
      endcase
    end
    setVec[SRC_KEY] = ~(&s_reg.keyS2) & ~s_reg.keySeen;
    s_next.keySeen = ~(&s_reg.keyS2);
    for (int i = 0; i < NUM_EXT; i++) begin
      unique case (s_reg.extMode[i])
        EXT_RISE: setVec[SRC_EXT0 + i] = s_reg.extS2[i] & ~s_reg.extPrev[i];
        EXT_BOTH: setVec[SRC_EXT0 + i] = s_reg.extS2[i] ^ s_reg.extPrev[i];
        EXT_LOW: setVec[SRC_EXT0 + i] = ~s_reg.extS2[i];
        EXT_HIGH: setVec[SRC_EXT0 + i] = s_reg.extS2[i];
        default: setVec[SRC_EXT0 + i] = ~s_reg.extS2[i] & s_reg.extPrev[i];
      endcase
    end

    // highest level above IPL, lowest index on tie
    for (int k = 0; k < NUM_PERIPH; k++) begin
      if (s_reg.pend[k] && s_reg.level[k] > bestLvl) begin
        bestLvl = s_reg.level[k];
        bestIdx = SWNUM_W'(k);
        found = 1'b1;
      end
    end

    // special sources ignore the global enable
    if (cpuReady && !s_reg.grantValid && !s_reg.resetRequest) begin
      take = 1'b1;
      s_next.grantVector = '0;
      if (s_reg.spec[SP_NMI]) begin
        s_next.grantKind = GK_NMI;
        specClr[SP_NMI] = 1'b1;
      end else if (s_reg.spec[SP_WDT]) begin
        s_next.grantKind = GK_WDT;
        specClr[SP_WDT] = 1'b1;
      end else if (s_reg.spec[SP_AM]) begin
        s_next.grantKind = GK_AMATCH;
        specClr[SP_AM] = 1'b1;
      end else if (s_reg.spec[SP_STEP]) begin
        s_next.grantKind = GK_STEP;
        specClr[SP_STEP] = 1'b1;
      end else if (s_reg.spec[SP_UND]) begin
        s_next.grantKind = GK_UND;
        specClr[SP_UND] = 1'b1;
      end else if (s_reg.spec[SP_OVF]) begin
        s_next.grantKind = GK_OVF;
        specClr[SP_OVF] = 1'b1;
      end else if (s_reg.spec[SP_BRK]) begin
        s_next.grantKind = GK_BRK;
        s_next.grantVector = SWNUM_W'(BRK_VECTOR);
        s_next.grantStackSwitch = 1'b1;
        specClr[SP_BRK] = 1'b1;
      end else if (s_reg.spec[SP_DEBUG_BREAK_OP]) begin
        s_next.grantKind = GK_DEBUG_BREAK_OP;
        specClr[SP_DEBUG_BREAK_OP] = 1'b1;
      end else if (s_reg.spec[SP_SW]) begin
        // number picks vector and stack switch
        s_next.grantKind = GK_SWINT;
        s_next.grantVector = s_reg.swNum;
        s_next.grantStackSwitch = s_reg.swNum < SWNUM_W'(SW_STACK_LIMIT);
        specClr[SP_SW] = 1'b1;
      end else if (found && s_reg.iEn) begin
        s_next.grantKind = GK_PERIPH;
        s_next.grantVector = SWNUM_W'(PERIPH_VEC_BASE) + bestIdx;
        s_next.grantStackSwitch = 1'b1;
        clrVec[bestIdx] = 1'b1;
      end else begin
        // Nothing taken: the last grant's vector stays on show
        take = 1'b0;
        s_next.grantVector = s_reg.grantVector;
      end
    end
    if (take) begin
      s_next.grantValid = 1'b1;
      s_next.uSaved = s_reg.uFlag;
      if (s_next.grantStackSwitch) begin
        s_next.uFlag = 1'b0;
      end
    end else if (intReturn) begin
      s_next.uFlag = s_reg.uSaved;
    end else if (stackSelWrite) begin
      s_next.uFlag = stackSelValue;
    end

    // APB read mux
    unique case (paddr)
      REG_CTRL: begin
        rdWord[CTRL_IEN] = s_reg.iEn;
        rdWord[CTRL_STEP] = s_reg.dStep;
        rdWord[CTRL_AMEN] = s_reg.amEn;
        rdWord[CTRL_IPL_LSB +: LVL_W] = s_reg.ipl;
        rdWord[CTRL_SER_LSB +: NUM_BUSCOL*SER_MODE_W] = s_reg.serMode;
      end
      REG_MATCH: rdWord[ADDR_W-1:0] = s_reg.matchAddr;
      REG_EXTMODE: rdWord[NUM_EXT*EXT_MODE_W-1:0] = s_reg.extMode;
      REG_PEND_LO: rdWord = s_reg.pend[PEND_LO_W-1:0];
      REG_PEND_HI: rdWord[NUM_PERIPH-PEND_LO_W-1:0] = s_reg.pend[NUM_PERIPH-1:PEND_LO_W];
      REG_STATUS: begin
        rdWord[STAT_OVF] = s_reg.ovfFlag;
        rdWord[STAT_USEL] = s_reg.uFlag;
        rdWord[STAT_USAVED] = s_reg.uSaved;
        rdWord[STAT_SPEC_LSB +: NUM_SPEC] = s_reg.spec;
      end
      default: begin
        hit = 1'b0;
        for (int k = 0; k < NUM_PERIPH; k++) begin
          if (paddr == 8'(REG_LEVEL_BASE + 4 * (k / LEVELS_PER_WORD))) begin
            rdWord[(k % LEVELS_PER_WORD) * LEVEL_FIELD_W +: LVL_W] = s_reg.level[k];
            hit = 1'b1;
          end
        end
      end
    endcase

    if (psel && penable && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.pslverr = ~hit;
      s_next.prdata = pwrite ? 32'h0000_0000 : rdWord;
    end
    if (psel && penable && s_reg.pready && pwrite && !s_reg.pslverr) begin
      unique case (paddr)
        REG_CTRL: begin
          s_next.iEn = pwdata[CTRL_IEN];
          s_next.dStep = pwdata[CTRL_STEP];
          s_next.amEn = pwdata[CTRL_AMEN];
          s_next.ipl = pwdata[CTRL_IPL_LSB +: LVL_W];
          s_next.serMode = pwdata[CTRL_SER_LSB +: NUM_BUSCOL*SER_MODE_W];
        end
        REG_MATCH: s_next.matchAddr = pwdata[ADDR_W-1:0];
        REG_EXTMODE: s_next.extMode = pwdata[NUM_EXT*EXT_MODE_W-1:0];
        REG_PEND_LO: clrVec[PEND_LO_W-1:0] = clrVec[PEND_LO_W-1:0] | pwdata;
        REG_PEND_HI: begin
          clrVec[NUM_PERIPH-1:PEND_LO_W] = clrVec[NUM_PERIPH-1:PEND_LO_W]
            | pwdata[NUM_PERIPH-PEND_LO_W-1:0];
        end
        default: begin
          for (int k = 0; k < NUM_PERIPH; k++) begin
            if (paddr == 8'(REG_LEVEL_BASE + 4 * (k / LEVELS_PER_WORD))) begin
              s_next.level[k] = pwdata[(k % LEVELS_PER_WORD) * LEVEL_FIELD_W +: LVL_W];
            end
          end
        end
      endcase
    end

    // New events win over clears
    s_next.pend = (s_reg.pend & ~clrVec) | setVec;
    s_next.spec = (s_reg.spec & ~specClr) | specSet;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.rstS1 <= 1'b1;
      s_reg.rstS2 <= 1'b1;
      s_reg.nmiS1 <= 1'b1;
      s_reg.nmiS2 <= 1'b1;
      s_reg.keyS1 <= '1;
      s_reg.keyS2 <= '1;
      s_reg.grantKind <= GK_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign grantValid = s_reg.grantValid;
  assign grantKind = s_reg.grantKind;
  assign grantVector = s_reg.grantVector;
  assign grantStackSwitch = s_reg.grantStackSwitch;
  assign stackSelFlag = s_reg.uFlag;
  assign ovfFlag = s_reg.ovfFlag;
  assign resetRequest = s_reg.resetRequest;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  periph_mask_a: assert property (s_next.grantValid && s_next.grantKind == GK_PERIPH |->
    s_reg.iEn && s_reg.level[s_next.grantVector - 6'(PERIPH_VEC_BASE)] > s_reg.ipl)
    else $error("peripheral grant without enable or level");
  und_trap_a: assert property (illegalOpExec |=> s_reg.spec[SP_UND])
    else $error("illegal op not raised");
  ovf_gate_a: assert property (overflowTrapExec && !ovfFlag && !s_reg.spec[SP_OVF] |=>
    !s_reg.spec[SP_OVF])
    else $error("overflow trap without flag");
  sw_low_stack_a: assert property (grantValid && grantKind == GK_SWINT &&
    grantVector < 6'(SW_STACK_LIMIT) |-> grantStackSwitch && !stackSelFlag)
    else $error("low software number kept stack select");
  sw_high_stack_a: assert property (grantValid && grantKind == GK_SWINT &&
    grantVector >= 6'(SW_STACK_LIMIT) |-> !grantStackSwitch && stackSelFlag == $past(stackSelFlag))
    else $error("high software number changed stack select");
  periph_stack_a: assert property (grantValid && grantKind == GK_PERIPH |->
    !stackSelFlag && grantVector >= 6'(PERIPH_VEC_BASE))
    else $error("peripheral grant kept stack or bad vector");
  reset_pin_a: assert property (!rstPin_b [*3] |=> resetRequest)
    else $error("reset pin low not seen");
  addr_match_a: assert property (s_reg.amEn && instrStart && instrAddr == s_reg.matchAddr |=>
    s_reg.spec[SP_AM])
    else $error("address match missed");
  step_trap_a: assert property (s_reg.dStep && instrDone |=> s_reg.spec[SP_STEP])
    else $error("single step missed");
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

endmodule : interrupt_source_classifier

// File: testbench/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pace and handshake
  input wire logic slow,
  output logic cpuReady
);
  logic [1:0] cntReg;

  // Slow core takes a grant one cycle in four
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cntReg <= 2'h0;
    end else begin
      cntReg <= cntReg + 2'h1;
    end
  end

  assign cpuReady = !slow || (cntReg == 2'h3);
endmodule : cpu_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import isc_pkg::*;
  typedef struct {
    logic [10:0] ev;
    logic [5:0] num;
    grant_kind_e kind;
    logic [5:0] vec;
    logic [1:0] sw;
  } row_s;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, ovfVal = 0;
  logic rstPin_b = 1, nmiPin_b = 1, pready, pslverr, err, cpuReady;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] keyPin_b = 4'hf;
  logic [5:0] extPin = 6'h29, num = 6'h00, grantVector;
  logic [10:0] ev = 11'h000;
  logic [34:0] per = 35'h0;
  logic [23:0] instrAddr = 24'h0;
  logic grantValid, grantStackSwitch, stackSelFlag, ovfFlag, resetRequest;
  grant_kind_e grantKind;
  int failures = 0, compares = 0;
  row_s rows[8];

  cpu_model partner (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow), .cpuReady(cpuReady));
  interrupt_source_classifier dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rstPin_b(rstPin_b), .nmiPin_b(nmiPin_b), .keyInputPin_b(keyPin_b),
    .externalRequestPin(extPin), .dmaReq(per[3:0]), .timerAReq(per[8:4]),
    .timerBReq(per[14:9]), .adReq(per[15]), .uartTxReq(per[20:16]),
    .uartRxReq(per[25:21]), .busCollision(per[28:26]), .startStopDet(per[31:29]),
    .faultErr(per[34:32]), .watchdogReq(ev[10]), .cpuReady(cpuReady),
    .instrStart(ev[5]), .instrDone(ev[6]), .instrAddr(instrAddr), .illegalOpExec(ev[0]),
    .overflowTrapExec(ev[1]), .breakOpExec(ev[2]), .debugBreakOpExec(ev[3]),
    .swTrapExec(ev[4]), .swTrapNum(num), .ovfUpdate(ev[7]), .ovfValue(ovfVal),
    .intReturn(ev[8]), .stackSelWrite(ev[9]), .stackSelValue(1'b1),
    .grantValid(grantValid), .grantKind(grantKind), .grantVector(grantVector),
    .grantStackSwitch(grantStackSwitch), .stackSelFlag(stackSelFlag), .ovfFlag(ovfFlag),
    .resetRequest(resetRequest));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic end_sim;
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang;
    failures++;
    $display("[FAIL] %0t no answer in time", $time);
    end_sim();
  endtask : hang

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Answer taken at the edge that sees pready high
    for (n = 0; n < 8; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n == 8) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input logic [10:0] c, input logic [34:0] p);
    @(posedge sys_clk);
    ev <= c;
    per <= p;
    @(posedge sys_clk);
    ev <= 11'h000;
    per <= 35'h0;
  endtask : pulse

  // Stack select set to 1 first, so a switch shows
  task automatic fire(input logic [10:0] c, input logic [34:0] p);
    pulse(11'h200, 35'h0);
    pulse(c, p);
  endtask : fire

  task automatic gr(input grant_kind_e k, input logic [5:0] v, input logic [1:0] sw);
    int n;
    for (n = 0; n < 12; n++) begin
      @(posedge sys_clk);
      if (grantValid === 1'b1) break;
    end
    if (n == 12) hang();
    chk(grantKind, k);
    chk(grantVector, v);
    if (sw != 2'h2) begin
      chk(grantStackSwitch, sw[0]);
      chk(stackSelFlag, !sw[0]);
    end
  endtask : gr

  task automatic nog;
    repeat (8) begin
      @(posedge sys_clk);
      chk(grantValid, 1'b0);
    end
  endtask : nog

  task automatic settle;
    repeat (8) @(posedge sys_clk);
    apb(1'b1, REG_PEND_LO, 32'hffffffff);
    apb(1'b1, REG_PEND_HI, 32'h0000000f);
    repeat (4) @(posedge sys_clk);
  endtask : settle

  initial begin
    int i;
    rows[0] = '{11'h001, 6'h00, GK_UND, 6'h00, 2'h2};
    rows[1] = '{11'h004, 6'h00, GK_BRK, 6'h00, 2'h1};
    rows[2] = '{11'h008, 6'h00, GK_DEBUG_BREAK_OP, 6'h00, 2'h2};
    rows[3] = '{11'h010, 6'h00, GK_SWINT, 6'h00, 2'h1};
    rows[4] = '{11'h010, 6'h1f, GK_SWINT, 6'h1f, 2'h1};
    rows[5] = '{11'h010, 6'h20, GK_SWINT, 6'h20, 2'h0};
    rows[6] = '{11'h010, 6'h2b, GK_SWINT, 6'h2b, 2'h0};
    rows[7] = '{11'h010, 6'h3f, GK_SWINT, 6'h3f, 2'h0};
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk(grantKind, GK_NONE);
    chk(stackSelFlag, 1'b0);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h80, 32'hffffffff);
    chk(err, 1'b1);
    apb(1'b0, 8'h80, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // Traps with global enable still off
    foreach (rows[j]) begin
      @(posedge sys_clk);
      num <= rows[j].num;
      fire(rows[j].ev, 35'h0);
      gr(rows[j].kind, rows[j].vec, rows[j].sw);
      pulse(11'h100, 35'h0);
      @(posedge sys_clk);
      chk(stackSelFlag, 1'b1);
    end
    fire(11'h005, 35'h0);
    gr(GK_UND, 6'h00, 2'h2);
    gr(GK_BRK, 6'h00, 2'h2);
    @(posedge sys_clk);
    ovfVal <= 1'b0;
    pulse(11'h080, 35'h0);
    pulse(11'h002, 35'h0);
    nog();
    chk(ovfFlag, 1'b0);
    ovfVal <= 1'b1;
    pulse(11'h080, 35'h0);
    pulse(11'h002, 35'h0);
    gr(GK_OVF, 6'h00, 2'h2);
    chk(ovfFlag, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[STAT_OVF], 1'b1);
    fire(11'h400, 35'h0);
    gr(GK_WDT, 6'h00, 2'h2);
    @(posedge sys_clk);
    nmiPin_b <= 1'b0;
    gr(GK_NMI, 6'h00, 2'h2);
    nmiPin_b <= 1'b1;
    rstPin_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(resetRequest, 1'b1);
    rstPin_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(resetRequest, 1'b0);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, REG_LEVEL_BASE + 8'(4 * i), 32'h11111111);
    end
    // Masked by enable, then by level not above IPL
    fire(11'h000, 35'h1);
    nog();
    apb(1'b1, REG_CTRL, 32'h00000011);
    nog();
    apb(1'b1, REG_CTRL, 32'h00000001);
    gr(GK_PERIPH, 6'h08, 2'h1);
    @(posedge sys_clk);
    slow <= 1'b1;
    for (i = 0; i < 29; i++) begin
      fire(11'h000, 35'h1 << i);
      gr(GK_PERIPH, 6'(8 + i), 2'h1);
    end
    slow <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h00002401);
    fire(11'h000, 35'h1 << 30);
    gr(GK_PERIPH, 6'h23, 2'h1);
    fire(11'h000, 35'h1 << 34);
    gr(GK_PERIPH, 6'h24, 2'h1);
    @(posedge sys_clk);
    keyPin_b <= 4'hb;
    gr(GK_PERIPH, 6'h25, 2'h2);
    keyPin_b <= 4'hf;
    apb(1'b1, REG_EXTMODE, 32'h00004688);
    settle();
    for (i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      extPin[i] <= ~extPin[i];
      gr(GK_PERIPH, 6'(38 + i), 2'h2);
      extPin <= 6'h29;
      settle();
    end
    apb(1'b1, REG_CTRL, 32'h00000005);
    apb(1'b1, REG_MATCH, 32'h00000123);
    @(posedge sys_clk);
    instrAddr <= 24'h000124;
    fire(11'h020, 35'h0);
    nog();
    instrAddr <= 24'h000123;
    fire(11'h020, 35'h0);
    gr(GK_AMATCH, 6'h00, 2'h2);
    apb(1'b1, REG_CTRL, 32'h00000003);
    fire(11'h040, 35'h0);
    gr(GK_STEP, 6'h00, 2'h2);
    end_sim();
  end
endmodule : tb
